// *** core/msdpsc_ctrl.sv ***
// power-state and command control with write data fifo
`timescale 1ns/1ns
`include "msdpsc_map.svh"

//----------------------------------------------------------------------
// write data fifo
//----------------------------------------------------------------------
module msdpsc_fifo #(
   parameter int WIDTH = 27,
   parameter int DEPTH = 32
) (
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];       // storage
   logic [AW-1:0]    wr_ptr_reg;        // write pointer
   logic [AW-1:0]    rd_ptr_reg;        // read pointer
   logic [AW:0]      count_reg;         // words held
   logic             push;
   logic             pop;
   logic [AW:0]      count_next;        // words held after this edge

   assign push       = in_valid && in_ready;
   assign pop        = out_valid && out_ready;
   assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
   assign out_data  = mem[rd_ptr_reg];

   // storage write
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // pointers and count
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
         in_ready   <= 1'b1;
         out_valid  <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         // flags follow the next level so the ports come from flops
         count_reg <= count_next;
         in_ready  <= (count_next != DEPTH[AW:0]);
         out_valid <= (count_next != '0);
      end
   end
endmodule

//----------------------------------------------------------------------
// top: command decode, power states, banks, bursts
//----------------------------------------------------------------------
module msdpsc_ctrl
   import msdpsc_pkg::*;
#(
   parameter int FIFO_DEPTH = 32,
   parameter int SRFX_CYC   = `MSD_SRFX_CYC
) (
   input  wire logic            clk_sys,
   input  wire logic            reset_n,
   input  wire msdpsc_cmd_bus_s cmd_in,
   input  wire logic            dqm,
   input  wire logic [15:0]     wr_data,
   output msdpsc_state_e        power_state_reg,
   output logic                 clock_suspend_reg,
   output logic [3:0]           bank_open_reg,
   output logic                 burst_active_reg,
   output logic [12:0]          mode_reg,
   output logic [12:0]          ext_mode_reg,
   output logic                 illegal_cmd_reg,
   output logic                 refresh_pulse_reg,
   output logic                 wr_ready,
   output logic                 arr_valid,
   input  wire logic            arr_ready,
   output msdpsc_wr_word_s      arr_word
);
   // burst length decode, shared by reads and writes
   function automatic logic [8:0] burst_len(input logic [2:0] code);
      case (code)
         3'h0:    burst_len = 9'h001;
         3'h1:    burst_len = 9'h002;
         3'h2:    burst_len = 9'h004;
         3'h3:    burst_len = 9'h008;
         default: burst_len = 9'h100;
      endcase
   endfunction

   // pin decode
   function automatic msdpsc_cmd_e decode(input msdpsc_cmd_bus_s c);
      if (c.cs_n) begin
         decode = MSD_NOP;
      end else begin
         case ({c.ras_n, c.cas_n, c.we_n})
            3'h3:    decode = MSD_ACT;
            3'h5:    decode = MSD_RD;
            3'h4:    decode = MSD_WR;
            3'h2:    decode = MSD_PRE;
            3'h6:    decode = MSD_BST;
            3'h1:    decode = MSD_REF;
            3'h0:    decode = MSD_MRS;
            default: decode = MSD_NOP;
         endcase
      end
   endfunction

   logic             cke_prev_reg;      // clock enable of previous edge
   logic [7:0]       wait_cnt_reg;      // exit and mode-set wait
   logic [1:0]       burst_bank_reg;    // bank of running burst
   logic [8:0]       burst_col_reg;     // next beat column
   logic [8:0]       burst_cnt_reg;     // beats left, zero = close only
   logic             burst_wr_reg;      // running burst is a write
   logic             burst_ap_reg;      // running burst auto precharges
   logic             burst_full_reg;    // full page, no count end
   msdpsc_cmd_e      cmd;               // decoded command
   logic             live;              // internal clock running
   logic             low_pwr;           // any state but active: idle, waits, power down, self refresh
   logic             step;              // burst advances this edge
   logic             stop_now;          // precharge or stop hits burst
   logic             cmd_beat;          // write command carries data
   logic             push;              // word into fifo
   logic [8:0]       new_len;           // length of new burst
   msdpsc_wr_word_s  push_word;

   assign cmd      = decode(cmd_in);
   assign live     = cke_prev_reg;
   assign low_pwr  = (power_state_reg != MSD_ACTIVE);
   assign step     = burst_active_reg && live;
   assign stop_now = live && ((cmd == MSD_BST) ||
                     ((cmd == MSD_PRE) && (cmd_in.addr[`MSD_AP_BIT] || cmd_in.ba == burst_bank_reg)));
   assign cmd_beat = live && (cmd == MSD_WR) && (power_state_reg == MSD_ACTIVE);
   assign new_len  = (cmd == MSD_WR && mode_reg[`MSD_MR_BURST_READ_SINGLE_WRITE_MODE_BIT]) ? 9'h001 :
                     burst_len(mode_reg[`MSD_MR_BL_LSB +: 3]);
   // data on a stop cycle or a precharge that hits the burst, and after it, is dropped
   assign push     = !dqm && (cmd_beat ||
                     (step && burst_wr_reg && burst_cnt_reg != '0 && !stop_now));
   assign push_word.ba   = cmd_beat ? cmd_in.ba : burst_bank_reg;
   assign push_word.col  = cmd_beat ? cmd_in.addr[8:0] : burst_col_reg;
   assign push_word.data = wr_data;

   // previous clock enable
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cke_prev_reg <= 1'b1;
      end else begin
         cke_prev_reg <= cmd_in.cke;
      end
   end

   // clock suspend follows clock enable one cycle late outside low power
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         clock_suspend_reg <= 1'b0;
      end else if (power_state_reg == MSD_ACTIVE) begin
         clock_suspend_reg <= !cmd_in.cke;
      end else begin
         clock_suspend_reg <= 1'b0;
      end
   end

   // power state machine
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         power_state_reg   <= MSD_IDLE;
         wait_cnt_reg      <= '0;
         illegal_cmd_reg   <= 1'b0;
         refresh_pulse_reg <= 1'b0;
      end else begin
         illegal_cmd_reg   <= 1'b0;
         refresh_pulse_reg <= 1'b0;
         case (power_state_reg)
            MSD_IDLE: begin
               if (live) begin
                  case (cmd)
                     // falling clock enable with nop enters power down
                     MSD_NOP: if (!cmd_in.cke) power_state_reg <= MSD_PDN;
                     MSD_ACT: power_state_reg <= MSD_ACTIVE;
                     MSD_REF: begin
                        if (!cmd_in.cke) begin
                           power_state_reg <= MSD_SREF;
                        end else begin
                           refresh_pulse_reg <= 1'b1;
                        end
                     end
                     MSD_MRS: begin
                        power_state_reg <= MSD_MRD;
                        wait_cnt_reg    <= 8'(`MSD_MRD_CYC - 1);
                     end
                     MSD_WR, MSD_RD, MSD_BST: illegal_cmd_reg <= 1'b1;
                     default: ;
                  endcase
               end
            end
            MSD_ACTIVE: begin
               // back to idle once every bank is closed and no burst runs
               // an activate on that same edge keeps the block active
               if (bank_open_reg == '0 && !burst_active_reg && !(live && cmd == MSD_ACT)) power_state_reg <= MSD_IDLE;
               if (live && (cmd == MSD_REF || cmd == MSD_MRS)) illegal_cmd_reg <= 1'b1;
            end
            MSD_PDN: begin
               if (cmd_in.cke) begin
                  power_state_reg <= MSD_IDLE;
                  if (cmd != MSD_NOP) illegal_cmd_reg <= 1'b1;
               end
            end
            MSD_SREF: begin
               // held low keeps self refresh whatever else the pins do
               if (cmd_in.cke) begin
                  power_state_reg <= MSD_SRFX;
                  wait_cnt_reg    <= 8'(SRFX_CYC - 1);
                  if (cmd != MSD_NOP) illegal_cmd_reg <= 1'b1;
               end
            end
            MSD_SRFX, MSD_MRD: begin
               if (wait_cnt_reg == '0) begin
                  power_state_reg <= MSD_IDLE;
               end else begin
                  wait_cnt_reg <= wait_cnt_reg - 1'b1;
               end
            end
            default: power_state_reg <= MSD_IDLE;
         endcase
      end
   end

   // mode and extended mode registers
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         mode_reg     <= `MSD_MR_RESET;
         ext_mode_reg <= `MSD_EMR_RESET;
      end else if (live && cmd == MSD_MRS && power_state_reg == MSD_IDLE) begin
         if (cmd_in.ba == `MSD_EMRS_BA) begin
            ext_mode_reg <= cmd_in.addr;
         end else begin
            mode_reg <= cmd_in.addr;
         end
      end
   end

   // banks and burst progress
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         bank_open_reg    <= '0;
         burst_active_reg <= 1'b0;
         burst_bank_reg   <= '0;
         burst_col_reg    <= '0;
         burst_cnt_reg    <= '0;
         burst_wr_reg     <= 1'b0;
         burst_ap_reg     <= 1'b0;
         burst_full_reg   <= 1'b0;
      end else begin
         // suspended bursts hold column and count
         if (step) begin
            burst_col_reg <= burst_col_reg + 1'b1;
            if (!burst_full_reg && burst_cnt_reg <= 9'h001) begin
               burst_active_reg <= 1'b0;
               if (burst_ap_reg) bank_open_reg[burst_bank_reg] <= 1'b0;
            end else if (!burst_full_reg) begin
               burst_cnt_reg <= burst_cnt_reg - 1'b1;
            end
         end
         if (live && !low_pwr || live && cmd == MSD_ACT && power_state_reg == MSD_IDLE) begin
            case (cmd)
               MSD_ACT: bank_open_reg[cmd_in.ba] <= 1'b1;
               MSD_PRE: begin
                  if (cmd_in.addr[`MSD_AP_BIT]) begin
                     bank_open_reg <= '0;
                  end else begin
                     bank_open_reg[cmd_in.ba] <= 1'b0;
                  end
                  if (stop_now) burst_active_reg <= 1'b0;
               end
               MSD_BST: burst_active_reg <= 1'b0;
               MSD_RD, MSD_WR: begin
                  // another bank's access starts a pending auto precharge
                  if (burst_active_reg && burst_ap_reg && cmd_in.ba != burst_bank_reg) begin
                     bank_open_reg[burst_bank_reg] <= 1'b0;
                  end
                  burst_bank_reg   <= cmd_in.ba;
                  burst_col_reg    <= cmd_in.addr[8:0] + 1'b1;
                  burst_cnt_reg    <= new_len - 1'b1;
                  burst_wr_reg     <= (cmd == MSD_WR);
                  burst_ap_reg     <= cmd_in.addr[`MSD_AP_BIT];
                  burst_full_reg   <= (new_len == 9'h100);
                  // one-word burst stays only to close its bank next cycle
                  burst_active_reg <= (new_len != 9'h001) || cmd_in.addr[`MSD_AP_BIT];
               end
               default: ;
            endcase
         end
      end
   end

   // write words queue towards the array; back-pressure shows on wr_ready
   msdpsc_fifo #(
      .WIDTH ($bits(msdpsc_wr_word_s)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .in_valid  (push),
      .in_ready  (wr_ready),
      .in_data   (push_word),
      .out_valid (arr_valid),
      .out_ready (arr_ready),
      .out_data  (arr_word)
   );
endmodule

// *** core/msdpsc_map.svh ***
// constants of the mobile sdram power-state control block
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`ifndef MSDPSC_MAP_SVH
`define MSDPSC_MAP_SVH
`define MSD_CLK_NS        20
`define MSD_SRFX_NS       120
`define MSD_SRFX_CYC      ((`MSD_SRFX_NS + `MSD_CLK_NS - 1) / `MSD_CLK_NS)
`define MSD_MRD_CYC       2
`define MSD_MR_BL_LSB     0
`define MSD_MR_BURST_READ_SINGLE_WRITE_MODE_BIT   9
`define MSD_AP_BIT        10
`define MSD_EMR_PARTIAL_ARRAY_REFRESH_SELECT_LSB  0
`define MSD_EMR_DS_LSB    5
`define MSD_EMRS_BA       2'h2
`define MSD_MR_RESET      13'h0000
`define MSD_EMR_RESET     13'h0000
`define MSD_BL_FULL       3'h7
`endif

// *** core/msdpsc_pkg.sv ***
// types of the mobile sdram power-state control block
package msdpsc_pkg;
   // power and operating states
   typedef enum logic [2:0] {
      MSD_IDLE, MSD_ACTIVE, MSD_PDN, MSD_SREF, MSD_SRFX, MSD_MRD
   } msdpsc_state_e;
   // decoded commands
   typedef enum logic [2:0] {
      MSD_NOP, MSD_ACT, MSD_RD, MSD_WR, MSD_PRE, MSD_BST, MSD_REF, MSD_MRS
   } msdpsc_cmd_e;
   // command pins sampled each edge
   typedef struct packed {
      logic        cke;
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [1:0]  ba;
      logic [12:0] addr;
   } msdpsc_cmd_bus_s;
   // one stored write word towards the array
   typedef struct packed {
      logic [1:0]  ba;
      logic [8:0]  col;
      logic [15:0] data;
   } msdpsc_wr_word_s;
endpackage

// *** sim/msdpsc_ctrl_assertions.sv ***
// port checker of the power-state control block
`timescale 1ns/1ns
module msdpsc_checker
   import msdpsc_pkg::*;
(
   input wire logic            clk_sys,
   input wire logic            reset_n,
   input wire msdpsc_cmd_bus_s cmd_in,
   input wire msdpsc_state_e   power_state_reg,
   input wire logic            clock_suspend_reg,
   input wire logic [3:0]      bank_open_reg,
   input wire logic [12:0]     mode_reg,
   input wire logic            illegal_cmd_reg
);
   //----------------------------------------------------------------------
   // helper logic
   //----------------------------------------------------------------------
   logic      cke_q;                                                     // clock enable of the previous edge
   wire [3:0] pins = {cmd_in.cs_n, cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n}; // command pins
   wire       live = cke_q & cmd_in.cke;                                 // command really taken
   wire       idle = power_state_reg == MSD_IDLE;                        // all banks idle
   // previous clock enable, high out of reset
   always_ff @(posedge clk_sys) begin
      cke_q <= reset_n ? cmd_in.cke : 1'b1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   //----------------------------------------------------------------------
   // low-power states
   //----------------------------------------------------------------------
   a_sref_hold: assert property (
      power_state_reg == MSD_SREF && !cmd_in.cke |=> power_state_reg == MSD_SREF)
      else $error("self refresh left with clock enable low");
   a_pdn_hold: assert property (
      power_state_reg == MSD_PDN && !cmd_in.cke |=> power_state_reg == MSD_PDN)
      else $error("power down left with clock enable low");
   a_pdn_exit: assert property (
      power_state_reg == MSD_PDN && cmd_in.cke |=> idle)
      else $error("power down exit missed");
   a_pdn_illegal: assert property (
      power_state_reg == MSD_PDN && cmd_in.cke && !cmd_in.cs_n && pins != 4'h7 |=> illegal_cmd_reg)
      else $error("illegal power down exit not flagged");
   a_pdn_entry: assert property (
      idle && cke_q && !cmd_in.cke && (cmd_in.cs_n || pins == 4'h7) |=> power_state_reg == MSD_PDN)
      else $error("power down not entered");
   a_sref_entry: assert property (
      idle && cke_q && !cmd_in.cke && pins == 4'h1 |=> power_state_reg == MSD_SREF)
      else $error("self refresh not entered");
   //----------------------------------------------------------------------
   // suspend, mode set, single write
   //----------------------------------------------------------------------
   a_suspend_on: assert property (
      power_state_reg == MSD_ACTIVE && bank_open_reg != 4'h0 && !cmd_in.cke |=> clock_suspend_reg)
      else $error("clock suspend did not start");
   a_suspend_off: assert property (
      clock_suspend_reg && cmd_in.cke |=> !clock_suspend_reg)
      else $error("clock suspend did not end");
   a_mode_wait: assert property (
      idle && live && pins == 4'h0 |=> power_state_reg == MSD_MRD [*2] ##1 idle)
      else $error("mode set wait not two cycles");
   a_single_write: assert property (
      mode_reg[9] && power_state_reg == MSD_ACTIVE && live && pins == 4'h4 && cmd_in.addr[10]
      |=> ##1 !bank_open_reg[$past(cmd_in.ba, 2)])
      else $error("single write auto precharge late");
endmodule

// *** sim/msdpsc_host.sv ***
// host memory controller model driving the command pins
`timescale 1ns/1ns
module msdpsc_host
   import msdpsc_pkg::*;
(
   input  wire logic       clk_sys,
   output msdpsc_cmd_bus_s cmd_in,
   output logic            dqm,
   output logic [15:0]     wr_data
);
   // cs_n, ras_n, cas_n, we_n of each command code
   localparam logic [3:0] PINS [8] = '{4'hf, 4'h3, 4'h5, 4'h4, 4'h2, 4'h6, 4'h1, 4'h0};
   // power-up: clock enable high and deselect
   initial begin
      cmd_in = 20'hf8000;
      dqm = 1'h0;
      wr_data = 16'h0000;
   end
   // one command per clock, launched just after the edge; deselected lines toggle
   task automatic put(msdpsc_cmd_e op, logic [1:0] b, logic [12:0] a, logic k, logic m, logic [15:0] d);
      @(posedge clk_sys);
      cmd_in.cke <= k;
      {cmd_in.cs_n, cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n} <= PINS[op];
      cmd_in.ba <= op == MSD_NOP ? ~cmd_in.ba : b;
      cmd_in.addr <= op == MSD_NOP ? ~cmd_in.addr : a;
      dqm <= m;
      wr_data <= d;
   endtask
endmodule

// *** sim/test_mobile_sdram_power_state_control.sv ***
// self-checking bench of the power-state control block
`timescale 1ns/1ns
bind msdpsc_ctrl msdpsc_checker u_msdpsc_checker (.clk_sys(clk_sys), .reset_n(reset_n), .cmd_in(cmd_in),
   .power_state_reg(power_state_reg), .clock_suspend_reg(clock_suspend_reg), .bank_open_reg(bank_open_reg),
   .mode_reg(mode_reg), .illegal_cmd_reg(illegal_cmd_reg));
module test_mobile_sdram_power_state_control
   import msdpsc_pkg::*;
;
   localparam int   SRFX = 3;        // shortened self refresh exit wait
   localparam int   BURST_REF = 4096; // burst refresh count of this density
   logic            clk_sys = 1'b0;  // 50 MHz
   logic            reset_n;
   logic            stall;           // array side stalls
   logic            arr_ready = 1'b0;
   logic [15:0]     d;               // data of the last command
   logic [12:0]     e;               // extended mode value
   logic [26:0]     exp_q[$];        // words the array must receive
   int              n_mismatch, checked, n_ref;
   msdpsc_cmd_bus_s cmd_in;
   logic            dqm, clock_suspend_reg, burst_active_reg, illegal_cmd_reg;
   logic            refresh_pulse_reg, wr_ready, arr_valid;
   logic [15:0]     wr_data;
   logic [3:0]      bank_open_reg;
   logic [12:0]     mode_reg, ext_mode_reg;
   msdpsc_state_e   power_state_reg;
   msdpsc_wr_word_s arr_word;
   msdpsc_ctrl #(.FIFO_DEPTH(32), .SRFX_CYC(SRFX)) u_msdpsc_ctrl (.clk_sys(clk_sys), .reset_n(reset_n),
      .cmd_in(cmd_in), .dqm(dqm), .wr_data(wr_data), .power_state_reg(power_state_reg),
      .clock_suspend_reg(clock_suspend_reg), .bank_open_reg(bank_open_reg), .burst_active_reg(burst_active_reg),
      .mode_reg(mode_reg), .ext_mode_reg(ext_mode_reg), .illegal_cmd_reg(illegal_cmd_reg),
      .refresh_pulse_reg(refresh_pulse_reg), .wr_ready(wr_ready), .arr_valid(arr_valid),
      .arr_ready(arr_ready), .arr_word(arr_word));
   msdpsc_host u_msdpsc_host (.clk_sys(clk_sys), .cmd_in(cmd_in), .dqm(dqm), .wr_data(wr_data));
   always #10 clk_sys = ~clk_sys;
   //----------------------------------------------------------------------
   // tasks
   //----------------------------------------------------------------------
   // compare and count
   task automatic chk(logic [31:0] s, logic [31:0] x);
      checked++;
      if (s !== x) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, x);
      end
   endtask
   // one command with random data
   task automatic c(msdpsc_cmd_e o, logic [12:0] a = 13'h0000, logic k = 1'h1, logic [1:0] b = 2'h0,
                    logic m = 1'h0);
      d = 16'($urandom);
      u_msdpsc_host.put(o, b, a, k, m, d);
   endtask
   // state check once the edge has landed
   task automatic st(msdpsc_state_e s);
      #2;
      chk(power_state_reg, s);
   endtask
   // let the array side empty the fifo
   task automatic drain();
      stall <= 1'b0;
      repeat (160) c(MSD_NOP);
      chk(exp_q.size(), 0);
   endtask
   task automatic finish_test();
      if (n_mismatch == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // array side: random stalls, words compared in order
   always @(posedge clk_sys) begin
      arr_ready <= !stall & 1'($urandom);
      if (reset_n === 1'b1 && arr_valid === 1'b1 && arr_ready === 1'b1) begin
         chk(arr_word, exp_q.size() ? exp_q.pop_front() : 27'h7ffffff);
      end
      if (refresh_pulse_reg === 1'b1) n_ref++;
   end
   // watchdog
   initial begin
      #(30000 * 20);
      n_mismatch++;
      finish_test();
   end
   //----------------------------------------------------------------------
   // main sequence
   //----------------------------------------------------------------------
   initial begin
      void'($urandom(32'h31ba5401));
      reset_n = 1'b0;
      stall = 1'b0;
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      #2;
      chk(ext_mode_reg, 13'h0000);
      chk({wr_ready, arr_valid, bank_open_reg, power_state_reg}, {6'h20, MSD_IDLE});
      repeat (10000) c(MSD_NOP);
      c(MSD_PRE, 13'h0400);
      c(MSD_REF);
      c(MSD_REF);
      c(MSD_MRS, 13'h0002);
      c(MSD_NOP);
      st(MSD_MRD);
      repeat (2) c(MSD_NOP);
      st(MSD_IDLE);
      e = 13'($urandom) & 13'h0067;
      c(MSD_MRS, e, 1'h1, 2'h2);
      repeat (3) c(MSD_NOP);
      chk({ext_mode_reg, mode_reg}, {e, 13'h0002});
      // power down: entry, hold under noise, exit, illegal exit
      repeat (2) c(MSD_NOP, 13'h0000, 1'h0);
      st(MSD_PDN);
      repeat (4) c(msdpsc_cmd_e'(3'($urandom)), 13'($urandom), 1'h0);
      st(MSD_PDN);
      repeat (2) c(MSD_NOP);
      st(MSD_IDLE);
      c(MSD_NOP, 13'h0000, 1'h0);
      c(MSD_RD);
      c(MSD_NOP);
      #2;
      chk({illegal_cmd_reg, power_state_reg}, {1'h1, MSD_IDLE});
      repeat (BURST_REF) c(MSD_REF);
      // self refresh under noise, exit wait
      c(MSD_REF, 13'h0000, 1'h0);
      repeat (5) c(msdpsc_cmd_e'(3'($urandom)), 13'($urandom), 1'h0);
      st(MSD_SREF);
      repeat (2) c(MSD_NOP);
      st(MSD_SRFX);
      repeat (SRFX) c(MSD_NOP);
      st(MSD_IDLE);
      repeat (BURST_REF) c(MSD_REF);
      // clock suspend with a bank open, then resume
      c(MSD_ACT, 13'($urandom));
      repeat (2) c(MSD_NOP, 13'h0000, 1'h0);
      #2;
      chk(clock_suspend_reg, 1'h1);
      repeat (2) c(MSD_NOP);
      #2;
      chk(clock_suspend_reg, 1'h0);
      // read cut by a write, data masked three cycles ahead
      c(MSD_NOP, 13'h0000, 1'h1, 2'h0, 1'h1);
      c(MSD_RD, 13'h0000, 1'h1, 2'h0, 1'h1);
      c(MSD_NOP, 13'h0000, 1'h1, 2'h0, 1'h1);
      c(MSD_WR, 13'h0005);
      exp_q.push_back({2'h0, 9'h005, d});
      c(MSD_NOP);
      exp_q.push_back({2'h0, 9'h006, d});
      c(MSD_PRE, 13'h0000, 1'h1, 2'h0, 1'h1);
      repeat (4) c(MSD_NOP);
      chk(bank_open_reg, 4'h0);
      drain();
      // full page write into a stalled fifo, ended by burst stop
      c(MSD_MRS, 13'h0007);
      repeat (3) c(MSD_NOP);
      c(MSD_ACT, 13'($urandom));
      c(MSD_NOP);
      stall <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         c(i ? MSD_NOP : MSD_WR);
         if (i < 32) exp_q.push_back({2'h0, 9'(i), d});
      end
      #2;
      chk({wr_ready, burst_active_reg}, 2'h1);
      c(MSD_BST);
      repeat (2) c(MSD_NOP);
      chk(burst_active_reg, 1'h0);
      drain();
      // single-write mode with auto precharge
      c(MSD_PRE, 13'h0400);
      repeat (3) c(MSD_NOP);
      c(MSD_MRS, 13'h0202);
      repeat (3) c(MSD_NOP);
      c(MSD_ACT, 13'($urandom), 1'h1, 2'h1);
      c(MSD_NOP);
      c(MSD_WR, 13'h0403, 1'h1, 2'h1);
      exp_q.push_back({2'h1, 9'h003, d});
      repeat (3) c(MSD_NOP);
      chk({bank_open_reg, burst_active_reg}, 5'h00);
      // auto precharge read overtaken by a read of another bank
      c(MSD_ACT, 13'($urandom), 1'h1, 2'h1);
      c(MSD_ACT, 13'($urandom), 1'h1, 2'h2);
      c(MSD_NOP);
      c(MSD_RD, 13'h0400, 1'h1, 2'h1);
      c(MSD_RD, 13'h0000, 1'h1, 2'h2);
      c(MSD_NOP);
      #2;
      chk(bank_open_reg, 4'h4);
      drain();
      chk(n_ref, 2 + 2 * BURST_REF);
      finish_test();
   end
endmodule
